// file: verilog/srp_defines.vh
// Constants for the shift, rotate and port transfer core
`ifndef SRP_DEFINES_VH
`define SRP_DEFINES_VH
`define SRP_OPC_HI 17
`define SRP_OPC_LO 13
`define SRP_REG_HI 12
`define SRP_REG_LO 8
`define SRP_SUB_HI 7
`define SRP_SUB_LO 3
`define SRP_VAR_HI 2
`define SRP_VAR_LO 0
`define SRP_OPC_SHIFT 5'h14
`define SRP_SUB_RIGHT 5'h01
`define SRP_SUB_LEFT 5'h00
`define SRP_V_FILL_ZERO 3'h6
`define SRP_V_FILL_ONE 3'h7
`define SRP_VR_EXTEND 3'h2
`define SRP_VR_ROTATE 3'h4
`define SRP_VL_EXTEND 3'h4
`define SRP_VL_ROTATE 3'h2
`define SRP_V_CARRY 3'h0
`define SRP_RST_HOLD 2
`endif

// file: verilog/srp_regfile.v
// Register file with registered read port
`timescale 1ns/1ns
`default_nettype none
module srp_regfile #(
    parameter AW = 5,
    parameter DW = 8
) (
    input wire ref_clk,
    input wire we,
    input wire [AW-1:0] waddr,
    input wire [DW-1:0] wdata,
    input wire [AW-1:0] raddr,
    output reg [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    always @(posedge ref_clk)
    begin
        if (we)
            mem[waddr] <= wdata;
        rdata <= mem[raddr];
    end
endmodule // srp_regfile
`default_nettype wire

// file: verilog/srp_core.v
// Shift and rotate execution, port transfers and internal reset filter
`timescale 1ns/1ns
`default_nettype none
`include "srp_defines.vh"
module srp_core #(
    parameter RST_HOLD = `SRP_RST_HOLD
) (
    input wire ref_clk,
    input wire arst_n,
    input wire reset,
    input wire [17:0] instr,
    input wire instr_valid,
    input wire port_read,
    input wire port_write,
    input wire [4:0] port_reg,
    input wire [7:0] port_addr,
    input wire [7:0] in_data,
    output reg busy_q,
    output reg [7:0] port_select_q,
    output reg [7:0] out_data_q,
    output reg read_strobe_q,
    output reg write_strobe_q,
    output reg carry_q,
    output reg zero_q,
    output reg int_reset_q
);
    localparam ST_IDLE = 2'h0;
    localparam ST_RD = 2'h1;
    localparam ST_WR = 2'h2;
    localparam ST_SH = 2'h3;

    reg rst_s1_q;
    reg rst_s2_q;
    reg [1:0] hold_q;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [1:0] phase_q;
    reg [4:0] reg_q;
    reg [2:0] var_q;
    reg right_q;
    reg sh_start;
    reg rd_start;
    reg wr_start;
    reg we;
    reg [7:0] wdata;
    reg [8:0] sh_res;
    wire [7:0] rdata;
    wire dec_right;
    wire dec_left;

    // Reset input is a pin: two flops, then hold counter
    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= 1'b1;
            hold_q <= 2'h0;
            int_reset_q <= 1'b1;
        end
        else
        begin
            rst_s1_q <= reset;
            rst_s2_q <= rst_s1_q;
            // Starts asserted, so a tied-low input still gives a clean start
            if (rst_s2_q)
            begin
                hold_q <= 2'h0;
                int_reset_q <= 1'b1;
            end
            else if (hold_q < RST_HOLD[1:0])
            begin
                hold_q <= hold_q + 2'h1;
                int_reset_q <= 1'b1;
            end
            else
                int_reset_q <= 1'b0;
        end
    end

    function [8:0] shift_op;
        input right;
        input [2:0] v;
        input [7:0] a;
        input c;
        reg fill;
        begin
            fill = 1'b0;
            if (right)
            begin
                if (v == `SRP_V_FILL_ONE)
                    fill = 1'b1;
                else if (v == `SRP_VR_EXTEND)
                    fill = a[7];
                else if (v == `SRP_VR_ROTATE)
                    fill = a[0];
                else if (v == `SRP_V_CARRY)
                    fill = c;
                shift_op = {a[0], fill, a[7:1]};
            end
            else
            begin
                if (v == `SRP_V_FILL_ONE)
                    fill = 1'b1;
                else if (v == `SRP_VL_EXTEND)
                    fill = a[0];
                else if (v == `SRP_VL_ROTATE)
                    fill = a[7];
                else if (v == `SRP_V_CARRY)
                    fill = c;
                shift_op = {a[7], a[6:0], fill};
            end
        end
    endfunction

    function valid_var;
        input right;
        input [2:0] v;
        begin
            // Extend and rotate codes swap between the two directions
            valid_var = (v == `SRP_V_FILL_ZERO) || (v == `SRP_V_FILL_ONE) ||
                (v == `SRP_V_CARRY) ||
                (right ? (v == `SRP_VR_EXTEND) || (v == `SRP_VR_ROTATE)
                    : (v == `SRP_VL_EXTEND) || (v == `SRP_VL_ROTATE));
        end
    endfunction

    assign dec_right = instr[`SRP_OPC_HI:`SRP_OPC_LO] == `SRP_OPC_SHIFT &&
        instr[`SRP_SUB_HI:`SRP_SUB_LO] == `SRP_SUB_RIGHT &&
        valid_var(1'b1, instr[`SRP_VAR_HI:`SRP_VAR_LO]);
    assign dec_left = instr[`SRP_OPC_HI:`SRP_OPC_LO] == `SRP_OPC_SHIFT &&
        instr[`SRP_SUB_HI:`SRP_SUB_LO] == `SRP_SUB_LEFT &&
        valid_var(1'b0, instr[`SRP_VAR_HI:`SRP_VAR_LO]);

    always @*
    begin
        state_d = state_q;
        sh_start = 1'b0;
        rd_start = 1'b0;
        wr_start = 1'b0;
        we = 1'b0;
        wdata = in_data;
        sh_res = shift_op(right_q, var_q, rdata, carry_q);
        case (state_q)
            ST_IDLE:
            begin
                // Port read wins over write, write over shift
                if (port_read)
                begin
                    rd_start = 1'b1;
                    state_d = ST_RD;
                end
                else if (port_write)
                begin
                    wr_start = 1'b1;
                    state_d = ST_WR;
                end
                else if (instr_valid && (dec_right || dec_left))
                begin
                    sh_start = 1'b1;
                    state_d = ST_SH;
                end
            end
            ST_RD:
                if (phase_q == 2'h1)
                begin
                    we = 1'b1;
                    state_d = ST_IDLE;
                end
            ST_WR:
                if (phase_q == 2'h1)
                    state_d = ST_IDLE;
            ST_SH:
                if (phase_q == 2'h1)
                begin
                    we = 1'b1;
                    wdata = sh_res[7:0];
                    state_d = ST_IDLE;
                end
            default:
                state_d = ST_IDLE;
        endcase
    end

    srp_regfile #(
        .AW(5),
        .DW(8)
    ) u_rf (
        .ref_clk(ref_clk),
        .we(we),
        .waddr(reg_q),
        .wdata(wdata),
        .raddr(state_q == ST_IDLE ? (port_write ? port_reg :
            instr[`SRP_REG_HI:`SRP_REG_LO]) : reg_q),
        .rdata(rdata)
    );

    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= ST_IDLE;
            phase_q <= 2'h0;
            reg_q <= 5'h00;
            var_q <= 3'h0;
            right_q <= 1'b0;
            busy_q <= 1'b0;
            port_select_q <= 8'h00;
            out_data_q <= 8'h00;
            read_strobe_q <= 1'b0;
            write_strobe_q <= 1'b0;
            carry_q <= 1'b0;
            zero_q <= 1'b0;
        end
        else if (int_reset_q || rst_s2_q)
        begin
            // Sampled input used too, so no pulse rises with the reset
            state_q <= ST_IDLE;
            phase_q <= 2'h0;
            busy_q <= 1'b0;
            read_strobe_q <= 1'b0;
            write_strobe_q <= 1'b0;
            carry_q <= 1'b0;
            zero_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            phase_q <= (state_q == ST_IDLE || state_d == ST_IDLE) ? 2'h0 :
                phase_q + 2'h1;
            busy_q <= state_d != ST_IDLE;
            read_strobe_q <= 1'b0;
            write_strobe_q <= 1'b0;
            if (rd_start || wr_start)
            begin
                reg_q <= port_reg;
                port_select_q <= port_addr; // Held both cycles
            end
            if (sh_start)
            begin
                reg_q <= instr[`SRP_REG_HI:`SRP_REG_LO];
                var_q <= instr[`SRP_VAR_HI:`SRP_VAR_LO];
                right_q <= dec_right;
            end
            // One-cycle pulse in the second transfer cycle
            if (state_q == ST_RD && phase_q == 2'h0)
                read_strobe_q <= 1'b1;
            if (state_q == ST_WR && phase_q == 2'h0)
                write_strobe_q <= 1'b1;
            // Read data comes out a cycle late, so latch it in cycle one
            if (state_q == ST_WR && phase_q == 2'h0)
                out_data_q <= rdata;
            if (state_q == ST_SH && phase_q == 2'h1)
            begin
                carry_q <= sh_res[8];
                zero_q <= sh_res[7:0] == 8'h00;
            end
        end
    end
endmodule // srp_core
`default_nettype wire

// file: verification/srp_core_sva.sv
// Checker for port transfers and internal reset of the core
`timescale 1ns/1ns
`default_nettype none
module srp_core_sva (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic reset,
    input wire logic port_read,
    input wire logic port_write,
    input wire logic [7:0] port_addr,
    input wire logic busy_q,
    input wire logic [7:0] port_select_q,
    input wire logic read_strobe_q,
    input wire logic write_strobe_q,
    input wire logic carry_q,
    input wire logic zero_q,
    input wire logic int_reset_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    xfer_len_a: assert property ($rose(busy_q)
        |-> ##1 busy_q ##1 !busy_q) else $error("transfer not two cycles");
    sel_stable_a: assert property (busy_q && $past(busy_q)
        |-> $stable(port_select_q)) else $error("select moved");
    sel_load_a: assert property ($rose(busy_q)
        && $past(port_read || port_write)
        |-> port_select_q == $past(port_addr))
        else $error("select not loaded");
    rd_second_a: assert property (read_strobe_q
        |-> busy_q && $past(busy_q) ##1 !read_strobe_q)
        else $error("read pulse misplaced");
    wr_second_a: assert property (write_strobe_q
        |-> busy_q && $past(busy_q) ##1 !write_strobe_q)
        else $error("write pulse misplaced");
    strobe_rst_a: assert property (int_reset_q
        |-> !read_strobe_q && !write_strobe_q)
        else $error("pulse in reset");
    refuse_rst_a: assert property (int_reset_q && !busy_q |=> !busy_q)
        else $error("request taken in reset");
    rst_hold_a: assert property ($fell(reset) |-> int_reset_q [*5])
        else $error("reset released early");
    rst_release_a: assert property ($fell(reset)
        |-> ##[5:8] !int_reset_q) else $error("reset never released");
    flags_io_a: assert property (read_strobe_q || write_strobe_q
        |=> $stable({carry_q, zero_q})) else $error("flags moved");
    cover property (read_strobe_q);
    cover property (write_strobe_q);
    cover property ($fell(int_reset_q));
endmodule // srp_core_sva
`default_nettype wire

// file: verification/srp_port_model.sv
// Port decode model: answers reads, captures writes
`timescale 1ns/1ns
`default_nettype none
module srp_port_model (
    input wire logic ref_clk,
    input wire logic [7:0] port_select_q,
    input wire logic [7:0] out_data_q,
    input wire logic read_strobe_q,
    input wire logic write_strobe_q,
    output logic [7:0] in_data,
    output logic [15:0] cap_q
);
    // Byte valid only in the capture cycle; inverted elsewhere to expose
    // early sampling
    assign in_data = read_strobe_q ? port_select_q ^ 8'ha5
                                   : ~(port_select_q ^ 8'ha5);
    always @(posedge ref_clk)
        if (write_strobe_q)
            cap_q <= {port_select_q, out_data_q};
endmodule // srp_port_model
`default_nettype wire

// file: verification/tb_shift_rotate_port_io_reset.sv
// Testbench for shifts, port transfers and reset filter
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb_shift_rotate_port_io_reset;
    logic ref_clk = 0, arst_n = 0, reset = 0, instr_valid = 0;
    logic port_read = 0, port_write = 0, c = 0;
    logic [17:0] instr = 0;
    logic [4:0] port_reg = 0;
    logic [7:0] port_addr = 0, out_data_q, port_select_q;
    logic [7:0] mem [32];
    logic [15:0] e, lastw, cap_q;
    logic [2:0] vr [5] = '{3'h6, 3'h7, 3'h2, 3'h0, 3'h4};
    logic [2:0] vl [5] = '{3'h6, 3'h7, 3'h4, 3'h0, 3'h2};
    wire [7:0] in_data;
    wire busy_q, read_strobe_q, write_strobe_q, carry_q, zero_q, int_reset_q;
    int n_mismatch = 0, comparisons = 0, n_rd = 0, exp_rd = 0, k;
    logic [15:0] q [$];
    srp_core #(.RST_HOLD(2)) srp_core_i (
        .ref_clk(ref_clk), .arst_n(arst_n), .reset(reset), .instr(instr),
        .instr_valid(instr_valid), .port_read(port_read),
        .port_write(port_write), .port_reg(port_reg), .port_addr(port_addr),
        .in_data(in_data), .busy_q(busy_q), .port_select_q(port_select_q),
        .out_data_q(out_data_q), .read_strobe_q(read_strobe_q),
        .write_strobe_q(write_strobe_q), .carry_q(carry_q), .zero_q(zero_q),
        .int_reset_q(int_reset_q)
    );
    srp_port_model srp_port_model_i (
        .ref_clk(ref_clk), .port_select_q(port_select_q),
        .out_data_q(out_data_q), .read_strobe_q(read_strobe_q),
        .write_strobe_q(write_strobe_q), .in_data(in_data), .cap_q(cap_q)
    );
    initial
    begin
        forever #10 ref_clk = ~ref_clk;
    end
    function automatic logic [8:0] shf(logic rt, logic [2:0] v, logic [7:0] a);
        logic f;
        if (rt)
        begin
            f = v == 3'h6 ? 0 : v == 3'h7 ? 1 : v == 3'h2 ? a[7] : v == 0 ? c : a[0];
            return {a[0], f, a[7:1]};
        end
        f = v == 3'h6 ? 0 : v == 3'h7 ? 1 : v == 3'h4 ? a[0] : v == 0 ? c : a[7];
        return {a[7], a[6:0], f};
    endfunction
    // Fixed three-cycle spacing: taken edge, first busy cycle, strobe cycle
    task go(logic r, w, v, logic [17:0] i, logic [4:0] g, logic [7:0] a);
        {port_read, port_write, instr_valid, instr} = {r, w, v, i};
        {port_reg, port_addr} = {g, a};
        @(posedge ref_clk);
        #1 {port_read, port_write, instr_valid} = 0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    task rd(logic [4:0] g, logic [7:0] a);
        mem[g] = a ^ 8'ha5;
        exp_rd++;
        go(1, 0, 0, 0, g, a);
    endtask
    task wr(logic [4:0] g, logic [7:0] a);
        lastw = {a, mem[g]};
        q.push_back(lastw);
        go(0, 1, 0, 0, g, a);
    endtask
    task sh(logic rt, logic [2:0] v, logic [4:0] g);
        logic [8:0] r;
        r = shf(rt, v, mem[g]);
        go(0, 0, 1, {5'h14, g, 4'h0, rt, v}, 0, 0);
        {c, mem[g]} = r;
        `CHK({carry_q, zero_q}, {r[8], r[7:0] == 0})
    endtask
    task wait_run;
        while (int_reset_q !== 1'b0)
        begin
            @(posedge ref_clk);
            #1;
        end
    endtask
    always @(negedge ref_clk)
    begin
        if (read_strobe_q === 1'b1)
            n_rd++;
        if (write_strobe_q === 1'b1)
        begin
            e = q.pop_front();
            `CHK({port_select_q, out_data_q}, e)
        end
    end
    task report_and_stop;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        #100000 n_mismatch++;
        report_and_stop;
    end
    initial
    begin
        void'($urandom(32'h3fcba508));
        repeat (5) @(posedge ref_clk);
        #1 arst_n = 1;
        wait_run;
        for (k = 0; k < 4; k++)
            rd(k[4:0], 8'($urandom));
        rd(5'h1f, 8'hff);
        rd(5'h1e, 8'h00);
        wr(5'h1f, 8'h00);
        wr(5'h1e, 8'hff);
        for (k = 0; k < 10; k++)
        begin
            sh(k < 5, k < 5 ? vr[k] : vl[k - 5], 0);
            wr(0, 8'($urandom));
        end
        wr(1, 8'($urandom));
        rd(2, 8'ha4);
        sh(1, 3'h6, 2);
        // Words with a wrong sub-field or variant must do nothing
        go(0, 0, 1, {5'h14, 5'd2, 5'h02, 3'h7}, 0, 0);
        go(0, 0, 1, {5'h14, 5'd2, 5'h00, 3'h5}, 0, 0);
        wr(2, 8'h3c);
        `CHK({carry_q, zero_q}, 2'b11)
        reset = 1;
        repeat (10) @(posedge ref_clk);
        #1;
        `CHK(int_reset_q, 1'b1)
        go(1, 0, 0, 0, 5'd3, 8'h11);
        reset = 0;
        wait_run;
        wr(3, 8'h22);
        `CHK(n_rd, exp_rd)
        `CHK(cap_q, lastw)
        `CHK(q.size(), 0)
        report_and_stop;
    end
endmodule // tb_shift_rotate_port_io_reset
bind srp_core srp_core_sva srp_core_sva_i (
    .ref_clk(ref_clk), .arst_n(arst_n), .reset(reset),
    .port_read(port_read), .port_write(port_write), .port_addr(port_addr),
    .busy_q(busy_q), .port_select_q(port_select_q),
    .read_strobe_q(read_strobe_q), .write_strobe_q(write_strobe_q),
    .carry_q(carry_q), .zero_q(zero_q), .int_reset_q(int_reset_q)
);
`default_nettype wire
